// *** shared/vdram_ctl_pkg.sv ***
// Constants, command codes and carrier types for the video DRAM random port controller.
// Assumes a single 50 MHz clock and an AXI4-Lite master on the software side.
// Behaviour
// RULE1 - Cycle type comes from strobe, enable and select levels at row and column fall.
// RULE2 - Masked write: select low at column fall; masked block write: select high.
// RULE3 - Register set: select high at column fall loads color, low loads write mask.
// RULE4 - Select high with mask/write low at row fall gives flash write.
// RULE5 - Transfer/output enable low at row fall starts a data transfer.
// RULE6 - Column strobe low at row fall starts refresh; select and mask pick variant.
// RULE7 - Option reset refresh sets all serial stop register bits to one.
// RULE8 - Old mask only after mask register load; new mask after option reset.
// RULE9 - Row strobe without column strobe only refreshes the row.
// RULE10 - Read: give addresses with strobes, then lower output enable; device drives data.
// RULE11 - Read data stays until strobes high, enable high or write enable low.
// RULE12 - For a read, enable high and select low at row fall, lowered afterwards.
// RULE13 - Extended-output page: data stays until the next column strobe fall.
// RULE14 - Unmasked write: mask/write high at row fall, low while strobes active.
// RULE15 - Early write: write enable low before column fall; data taken at column fall.
// RULE16 - Late write: data taken at write enable fall; output enable kept high.
// RULE17 - Read-modify-write: modified data driven only after output enable rises.
// RULE18 - Repeated column cycles under one row strobe access further columns.
// RULE19 - Write enable pulse after column rise floats data until next column cycle.
// RULE20 - Output enable high after column rise floats data until next column cycle.
// RULE21 - Flash write copies color register into all 512 columns, mask honoured.
// RULE22 - Block write fills four columns; data pins 0 to 3 select columns.
// RULE23 - Block write column pattern stands on pins at later of column or write fall.
// RULE24 - Mask bit one permits write of that data bit, zero leaves it.
// RULE25 - New-mask: mask on data pins at row fall; only high bits written.
// RULE26 - Device keeps a new/old mask selector set by option reset or mask load.
package vdram_ctl_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFF_CMD    = 8'h00;
	localparam logic [7:0] OFF_ADDR   = 8'h04;
	localparam logic [7:0] OFF_WDATA  = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_RDATA  = 8'h10;
	// Command register fields.
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_MASK_BIT = 4;
	localparam int CMD_START    = 31;
	// Operation codes.
	localparam logic [3:0] OP_READ      = 4'h0;
	localparam logic [3:0] OP_WRITE     = 4'h1;
	localparam logic [3:0] OP_BLOCK     = 4'h2;
	localparam logic [3:0] OP_COLOR     = 4'h3;
	localparam logic [3:0] OP_MASKREG   = 4'h4;
	localparam logic [3:0] OP_FLASH     = 4'h5;
	localparam logic [3:0] OP_XFER_RD   = 4'h6;
	localparam logic [3:0] OP_XFER_WR   = 4'h7;
	localparam logic [3:0] OP_OPT_RESET = 4'h8;
	localparam logic [3:0] OP_REFRESH   = 4'h9;
	localparam logic [3:0] OP_STOP_SET  = 4'hA;
	localparam logic [3:0] OP_ROW_ONLY  = 4'hB;
	localparam logic [3:0] OP_SPLIT_RD  = 4'hC;
	localparam logic [3:0] OP_SPLIT_WR  = 4'hD;
	// Timing: each strobe phase lasts at least this long.
	localparam int PHASE_NS     = 60;
	localparam int CLK_NS       = 20;
	localparam int PHASE_CYCLES = (PHASE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] PHASE_LAST = 2'(PHASE_CYCLES - 1);
	localparam logic [7:0] RESP_OKAY   = 8'h00;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_OK     = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_ROW   = 3'b011,
		ST_COL   = 3'b010,
		ST_DATA  = 3'b110,
		ST_DONE  = 3'b111
	} phase_t;

	// Pin group driven toward the memory.
	typedef struct packed {
		logic       ras_n;
		logic       cas_n;
		logic       transfer_output_enable_n;
		logic       mask_write_enable_n;
		logic       function_select;
		logic [8:0] addr;
	} strobes_t;
endpackage

// *** design/vdram_ctl.sv ***
// Host controller that sequences the random access port of a dual-port video DRAM.
// Assumes the memory pins are synchronous to CLK and software drives AXI4-Lite.
`timescale 1ns/10ps
module vdram_ctl (
	// Clock and reset
	input  wire logic                      CLK,
	input  wire logic                      SYS_RST,
	// AXI4-Lite slave
	input  wire logic [7:0]                S_AWADDR,
	input  wire logic                      S_AWVALID,
	output logic                           S_AWREADY,
	input  wire logic [31:0]               S_WDATA,
	input  wire logic [3:0]                S_WSTRB,
	input  wire logic                      S_WVALID,
	output logic                           S_WREADY,
	output logic [1:0]                     S_BRESP,
	output logic                           S_BVALID,
	input  wire logic                      S_BREADY,
	input  wire logic [7:0]                S_ARADDR,
	input  wire logic                      S_ARVALID,
	output logic                           S_ARREADY,
	output logic [31:0]                    S_RDATA,
	output logic [1:0]                     S_RRESP,
	output logic                           S_RVALID,
	input  wire logic                      S_RREADY,
	// Memory pins
	output vdram_ctl_pkg::strobes_t        PINS,
	output logic [7:0]                     MASK_DATA_PINS_O,
	output logic                           MASK_DATA_PINS_OE_N,
	input  wire logic [7:0]                MASK_DATA_PINS_I
);
	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	logic [3:0]  op, next_op;
	logic        use_mask, next_use_mask;
	logic [17:0] addr, next_addr;
	logic [7:0]  wdata, next_wdata;
	logic [7:0]  rdata, next_rdata;
	logic        busy, next_busy;
	logic        aw_hold, next_aw_hold, w_hold, next_w_hold;
	logic [7:0]  aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic        bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0]  bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdat, next_rdat;
	logic        start;

	assign S_AWREADY = !aw_hold && !bvalid;
	assign S_WREADY  = !w_hold && !bvalid;
	assign S_ARREADY = !rvalid;
	assign S_BVALID  = bvalid;
	assign S_BRESP   = bresp;
	assign S_RVALID  = rvalid;
	assign S_RRESP   = rresp;
	assign S_RDATA   = rdat;

	always_comb begin
		logic [7:0]  wa;
		logic [31:0] wd;
		wa = aw_hold ? aw_addr : S_AWADDR;
		wd = w_hold ? w_data : S_WDATA;
		next_aw_hold = aw_hold;
		next_w_hold  = w_hold;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rresp   = rresp;
		next_rdat    = rdat;
		next_op      = op;
		next_use_mask = use_mask;
		next_addr    = addr;
		next_wdata   = wdata;
		start        = 1'b0;
		if (S_AWVALID && S_AWREADY) begin
			next_aw_hold = 1'b1;
			next_aw_addr = S_AWADDR;
		end
		if (S_WVALID && S_WREADY) begin
			next_w_hold = 1'b1;
			next_w_data = S_WDATA;
		end
		if (next_aw_hold && next_w_hold && !bvalid) begin
			next_aw_hold = 1'b0;
			next_w_hold  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = vdram_ctl_pkg::RESP_OK;
			wa = next_aw_addr;
			wd = next_w_data;
			unique case (wa)
				vdram_ctl_pkg::OFF_CMD: begin
					if (S_WSTRB[0] && !busy) begin
						next_op       = wd[vdram_ctl_pkg::CMD_OP_LSB +: 4];
						next_use_mask = wd[vdram_ctl_pkg::CMD_MASK_BIT]; // [RULE8]
					end
					start = S_WSTRB[3] && wd[vdram_ctl_pkg::CMD_START] && !busy;
				end
				vdram_ctl_pkg::OFF_ADDR: begin
					if (S_WSTRB[0]) next_addr[7:0] = wd[7:0];
					if (S_WSTRB[1]) next_addr[15:8] = wd[15:8];
					if (S_WSTRB[2]) next_addr[17:16] = wd[17:16];
				end
				vdram_ctl_pkg::OFF_WDATA: begin
					if (S_WSTRB[0]) next_wdata = wd[7:0];
				end
				vdram_ctl_pkg::OFF_STATUS, vdram_ctl_pkg::OFF_RDATA: ;
				default: next_bresp = vdram_ctl_pkg::RESP_SLVERR;
			endcase
		end
		if (bvalid && S_BREADY) next_bvalid = 1'b0;
		if (S_ARVALID && S_ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp  = vdram_ctl_pkg::RESP_OK;
			unique case (S_ARADDR)
				vdram_ctl_pkg::OFF_CMD:    next_rdat = {27'h0, use_mask, op};
				vdram_ctl_pkg::OFF_ADDR:   next_rdat = {14'h0, addr};
				vdram_ctl_pkg::OFF_WDATA:  next_rdat = {24'h0, wdata};
				vdram_ctl_pkg::OFF_STATUS: next_rdat = {31'h0, busy};
				vdram_ctl_pkg::OFF_RDATA:  next_rdat = {24'h0, rdata};
				default: begin
					next_rdat  = 32'h0;
					next_rresp = vdram_ctl_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid && S_RREADY) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			aw_hold  <= 1'b0;
			w_hold   <= 1'b0;
			aw_addr  <= 8'h00;
			w_data   <= 32'h0;
			bvalid   <= 1'b0;
			bresp    <= 2'h0;
			rvalid   <= 1'b0;
			rresp    <= 2'h0;
			rdat     <= 32'h0;
			op       <= 4'h0;
			use_mask <= 1'b0;
			addr     <= 18'h0;
			wdata    <= 8'h00;
		end else begin
			aw_hold  <= next_aw_hold;
			w_hold   <= next_w_hold;
			aw_addr  <= next_aw_addr;
			w_data   <= next_w_data;
			bvalid   <= next_bvalid;
			bresp    <= next_bresp;
			rvalid   <= next_rvalid;
			rresp    <= next_rresp;
			rdat     <= next_rdat;
			op       <= next_op;
			use_mask <= next_use_mask;
			addr     <= next_addr;
			wdata    <= next_wdata;
		end
	end

	// ---------------------------------------------------------------
	// Strobe sequencer
	// ---------------------------------------------------------------
	// Levels at row fall for an opcode: column strobe, transfer/output enable, mask/write enable, select.
	// A read keeps the write enable high, or the column fall would be taken as a write.
	function automatic logic [3:0] row_levels(input logic [3:0] o, input logic m);
		unique case (o)
			vdram_ctl_pkg::OP_READ:      row_levels = 4'b1110;           // [RULE12]
			vdram_ctl_pkg::OP_WRITE:     row_levels = {2'b11, !m, 1'b0}; // [RULE2] [RULE14]
			vdram_ctl_pkg::OP_BLOCK:     row_levels = {2'b11, !m, 1'b0}; // [RULE2]
			vdram_ctl_pkg::OP_COLOR:     row_levels = 4'b1111;           // [RULE3]
			vdram_ctl_pkg::OP_MASKREG:   row_levels = 4'b1111;           // [RULE3]
			vdram_ctl_pkg::OP_FLASH:     row_levels = 4'b1101;           // [RULE4]
			vdram_ctl_pkg::OP_XFER_RD:   row_levels = 4'b1010;           // [RULE5]
			vdram_ctl_pkg::OP_SPLIT_RD:  row_levels = 4'b1011;           // [RULE5]
			vdram_ctl_pkg::OP_XFER_WR:   row_levels = 4'b1000;           // [RULE5]
			vdram_ctl_pkg::OP_SPLIT_WR:  row_levels = 4'b1001;           // [RULE5]
			vdram_ctl_pkg::OP_OPT_RESET: row_levels = 4'b0110;           // [RULE6] [RULE7]
			vdram_ctl_pkg::OP_REFRESH:   row_levels = 4'b0111;           // [RULE6]
			vdram_ctl_pkg::OP_STOP_SET:  row_levels = 4'b0101;           // [RULE6]
			default:                     row_levels = 4'b1110;           // [RULE9]
		endcase
	endfunction

	vdram_ctl_pkg::phase_t state, next_state;
	logic [1:0]  cnt, next_cnt;
	vdram_ctl_pkg::strobes_t pins, next_pins;
	logic [7:0]  dout, next_dout;
	logic        doe_n, next_doe_n;
	logic        has_col;

	assign has_col = (op != vdram_ctl_pkg::OP_ROW_ONLY) && (op != vdram_ctl_pkg::OP_OPT_RESET) &&
	                 (op != vdram_ctl_pkg::OP_REFRESH) && (op != vdram_ctl_pkg::OP_STOP_SET) &&
	                 (op != vdram_ctl_pkg::OP_FLASH);
	assign PINS                = pins;
	assign MASK_DATA_PINS_O    = dout;
	assign MASK_DATA_PINS_OE_N = doe_n;

	always_comb begin
		logic [3:0] lv;
		lv         = row_levels(op, use_mask);
		next_state = state;
		next_cnt   = (cnt == vdram_ctl_pkg::PHASE_LAST) ? 2'd0 : cnt + 2'd1;
		next_pins  = pins;
		next_dout  = dout;
		next_doe_n = doe_n;
		next_rdata = rdata;
		next_busy  = busy;
		unique case (state)
			vdram_ctl_pkg::ST_IDLE: begin
				next_cnt = 2'd0;
				if (start) begin
					next_busy  = 1'b1;
					next_state = vdram_ctl_pkg::ST_SETUP;
				end
			end
			vdram_ctl_pkg::ST_SETUP: begin
				// Row address and row-fall levels settle before the row strobe drops.
				next_pins.addr   = addr[17:9];
				next_pins.cas_n  = lv[3];
				next_pins.transfer_output_enable_n = lv[2];
				next_pins.mask_write_enable_n      = lv[1];
				next_pins.function_select          = lv[0];
				next_dout        = wdata;
				next_doe_n       = !(use_mask && op != vdram_ctl_pkg::OP_READ && lv[3]); // [RULE25]
				if (cnt == vdram_ctl_pkg::PHASE_LAST) next_state = vdram_ctl_pkg::ST_ROW;
			end
			vdram_ctl_pkg::ST_ROW: begin
				next_pins.ras_n = 1'b0; // [RULE1]
				if (cnt == vdram_ctl_pkg::PHASE_LAST) begin
					next_doe_n       = 1'b1;
					next_pins.addr   = addr[8:0];
					next_pins.transfer_output_enable_n = 1'b1; // [RULE16]
					next_pins.function_select = (op == vdram_ctl_pkg::OP_BLOCK) || // [RULE1]
					                            (op == vdram_ctl_pkg::OP_COLOR);
					if (op == vdram_ctl_pkg::OP_WRITE || op == vdram_ctl_pkg::OP_BLOCK) begin
						next_pins.mask_write_enable_n = 1'b0; // [RULE15]
						next_dout  = (op == vdram_ctl_pkg::OP_BLOCK) ? {4'h0, wdata[3:0]} : wdata; // [RULE22] [RULE23]
						next_doe_n = 1'b0; // [RULE17]
					end else if (op == vdram_ctl_pkg::OP_COLOR || op == vdram_ctl_pkg::OP_MASKREG) begin
						next_dout  = wdata;
						next_doe_n = 1'b0;
					end
					next_state = has_col ? vdram_ctl_pkg::ST_COL : vdram_ctl_pkg::ST_DONE; // [RULE9]
				end
			end
			vdram_ctl_pkg::ST_COL: begin
				next_pins.cas_n = 1'b0;
				if (op == vdram_ctl_pkg::OP_READ) next_pins.transfer_output_enable_n = 1'b0; // [RULE10]
				if (cnt == vdram_ctl_pkg::PHASE_LAST) next_state = vdram_ctl_pkg::ST_DATA;
			end
			vdram_ctl_pkg::ST_DATA: begin
				if (op == vdram_ctl_pkg::OP_READ) next_rdata = MASK_DATA_PINS_I; // [RULE11]
				// Precharge then lasts a full phase.
				next_cnt   = 2'd0;
				next_state = vdram_ctl_pkg::ST_DONE;
			end
			vdram_ctl_pkg::ST_DONE: begin
				next_pins.ras_n  = 1'b1;
				next_pins.cas_n  = 1'b1;
				next_pins.transfer_output_enable_n = 1'b1;
				next_pins.mask_write_enable_n      = 1'b1;
				next_doe_n       = 1'b1;
				if (cnt == vdram_ctl_pkg::PHASE_LAST) begin
					next_busy  = 1'b0;
					next_state = vdram_ctl_pkg::ST_IDLE;
				end
			end
			default: next_state = vdram_ctl_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state <= vdram_ctl_pkg::ST_IDLE;
			cnt   <= 2'd0;
			pins  <= '{ras_n: 1'b1, cas_n: 1'b1, transfer_output_enable_n: 1'b1,
			           mask_write_enable_n: 1'b1, function_select: 1'b0, addr: 9'h000};
			dout  <= 8'h00;
			doe_n <= 1'b1;
			rdata <= 8'h00;
			busy  <= 1'b0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			pins  <= next_pins;
			dout  <= next_dout;
			doe_n <= next_doe_n;
			rdata <= next_rdata;
			busy  <= next_busy;
		end
	end
endmodule

// *** test/vdram_ctl_assertions.sv ***
// Checker for the pin sequencing of the video DRAM random port controller.
// Assumes it is bound to vdram_ctl and sees only that module's ports.
`timescale 1ns/10ps
module vdram_ctl_checker (
	// Clock and reset
	input wire logic                    CLK,
	input wire logic                    SYS_RST,
	// Memory side
	input wire vdram_ctl_pkg::strobes_t PINS,
	input wire logic                    MASK_DATA_PINS_OE_N
);
	logic ras_q;
	logic rd_cyc;
	logic next_rd_cyc;
	wire logic oe_n = PINS.transfer_output_enable_n;
	wire logic we_n = PINS.mask_write_enable_n;
	wire logic fsel = PINS.function_select;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// Remembers whether the open row was started with read or write levels.
	always_comb begin
		next_rd_cyc = rd_cyc;
		if (!PINS.ras_n && ras_q)
			next_rd_cyc = PINS.cas_n && oe_n && !fsel;
	end
	always_ff @(posedge CLK) begin
		ras_q  <= SYS_RST | PINS.ras_n;
		rd_cyc <= !SYS_RST && next_rd_cyc;
	end
	strobe_setup_a: assert property ($fell(PINS.ras_n) |-> $stable(PINS.cas_n) && $stable(fsel))
		else $error("levels changed at row strobe fall");
	row_addr_a: assert property ($fell(PINS.ras_n) |-> $stable(PINS.addr) && $stable(we_n))
		else $error("row address not settled at row strobe fall");
	row_hold_a: assert property ($fell(PINS.ras_n) |-> !PINS.ras_n [*3])
		else $error("row strobe low for under three cycles");
	read_order_a: assert property ($fell(oe_n) |-> PINS.ras_n || !$past(PINS.ras_n))
		else $error("output enable fell together with row strobe");
	read_float_a: assert property (rd_cyc && !PINS.cas_n && !oe_n |-> MASK_DATA_PINS_OE_N)
		else $error("controller drives data while device outputs");
	early_write_a: assert property (rd_cyc && $fell(PINS.cas_n) && !we_n && !fsel
		|-> !$past(we_n) && !MASK_DATA_PINS_OE_N)
		else $error("write data or enable late at column strobe fall");
	new_mask_a: assert property ($fell(PINS.ras_n) && PINS.cas_n && oe_n && !fsel && !we_n
		|-> !MASK_DATA_PINS_OE_N)
		else $error("mask not driven at row strobe fall");
	block_pattern_a: assert property (rd_cyc && $fell(PINS.cas_n) && fsel && !we_n
		|-> !MASK_DATA_PINS_OE_N)
		else $error("column pattern not driven for block write");
	cover property ($fell(PINS.ras_n) && !PINS.cas_n);
	cover property (rd_cyc && $fell(oe_n));
	cover property (rd_cyc && $fell(PINS.cas_n) && fsel);
	cover property (rd_cyc && $fell(PINS.cas_n) && !we_n && !fsel);
endmodule

bind vdram_ctl vdram_ctl_checker vdram_ctl_checker_inst (.CLK(CLK), .SYS_RST(SYS_RST), .PINS(PINS),
	.MASK_DATA_PINS_OE_N(MASK_DATA_PINS_OE_N));

// *** test/vdram_model.sv ***
// Behavioural model of the random access port of the video DRAM.
// Assumes the bench resolves the shared data pins from both drivers.
`timescale 1ns/10ps
module vdram_model (
	// Strobes and data
	input  wire vdram_ctl_pkg::strobes_t p,
	input  wire logic [7:0]              dq,
	output logic [7:0]                   q,
	output logic                         drv
);
	logic [7:0] mem [0:262143];
	logic [7:0] color, mreg, msk, stop;
	logic [8:0] row, col;
	logic [3:0] op, last_op;
	logic       newmode;
	int         i;
	wire logic  oe_n = p.transfer_output_enable_n;
	wire logic  we_n = p.mask_write_enable_n;
	wire logic  fsel = p.function_select;
	initial begin
		newmode = 1'b1;
		drv     = 1'b0;
		q       = 8'h00;
	end
	function automatic logic [7:0] mrg(input logic [7:0] o, input logic [7:0] d);
		return (o & ~msk) | (d & msk);
	endfunction
	always @(negedge p.ras_n) begin
		#1;
		row = p.addr;
		msk = we_n ? 8'hFF : (newmode ? dq : mreg);
		if (!p.cas_n) begin
			op = fsel ? (we_n ? vdram_ctl_pkg::OP_REFRESH : vdram_ctl_pkg::OP_STOP_SET) : vdram_ctl_pkg::OP_OPT_RESET;
			if (!fsel)
				stop = 8'hFF;
			if (!fsel)
				newmode = 1'b1;
			if (fsel && !we_n)
				stop = p.addr[7:0];
		end else if (!oe_n) begin
			op = fsel ? (we_n ? vdram_ctl_pkg::OP_SPLIT_RD : vdram_ctl_pkg::OP_SPLIT_WR)
				: (we_n ? vdram_ctl_pkg::OP_XFER_RD : vdram_ctl_pkg::OP_XFER_WR);
		end else if (fsel && !we_n) begin
			op = vdram_ctl_pkg::OP_FLASH;
			for (i = 0; i < 512; i++)
				mem[{row, i[8:0]}] = mrg(mem[{row, i[8:0]}], color);
		end else
			op = fsel ? vdram_ctl_pkg::OP_COLOR : vdram_ctl_pkg::OP_ROW_ONLY;
	end
	always @(negedge p.cas_n) begin
		#1;
		col = p.addr;
		if (!p.ras_n && op == vdram_ctl_pkg::OP_COLOR && !fsel) begin
			op      = vdram_ctl_pkg::OP_MASKREG;
			mreg    = dq;
			newmode = 1'b0;
		end else if (!p.ras_n && op == vdram_ctl_pkg::OP_COLOR)
			color = dq;
		else if (!p.ras_n && op == vdram_ctl_pkg::OP_ROW_ONLY && !we_n && fsel) begin
			op = vdram_ctl_pkg::OP_BLOCK;
			for (i = 0; i < 4; i++)
				if (dq[i])
					mem[{row, col[8:2], i[1:0]}] = mrg(mem[{row, col[8:2], i[1:0]}], color);
		end else if (!p.ras_n && op == vdram_ctl_pkg::OP_ROW_ONLY && !we_n) begin
			op               = vdram_ctl_pkg::OP_WRITE;
			mem[{row, col}] = mrg(mem[{row, col}], dq);
		end else if (!p.ras_n && op == vdram_ctl_pkg::OP_ROW_ONLY)
			op = vdram_ctl_pkg::OP_READ;
	end
	always @(negedge p.cas_n or negedge oe_n) begin
		#2;
		if (op == vdram_ctl_pkg::OP_READ && !p.ras_n && !p.cas_n && !oe_n && we_n) begin
			q   = mem[{row, col}];
			drv = 1'b1;
		end
	end
	always @(posedge p.ras_n or posedge oe_n or negedge we_n) begin
		if ((p.ras_n && p.cas_n) || oe_n || !we_n)
			drv = 1'b0;
		if (p.ras_n)
			last_op = op;
	end
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the video DRAM random port controller.
// Assumes the device model in vdram_model.sv and register access over AXI4-Lite.
`timescale 1ns/10ps
module testbench;
	logic        CLK, SYS_RST, drv;
	logic [7:0]  S_AWADDR, S_ARADDR, dbus, q, MASK_DATA_PINS_O;
	logic [31:0] S_WDATA, S_RDATA, d;
	logic [3:0]  S_WSTRB;
	logic [1:0]  S_BRESP, S_RRESP, r;
	logic        S_AWVALID, S_AWREADY, S_WVALID, S_WREADY, S_BVALID, S_BREADY;
	logic        S_ARVALID, S_ARREADY, S_RVALID, S_RREADY, MASK_DATA_PINS_OE_N;
	logic [3:0]  ops [7];
	int          fail_count, check_count, k;
	vdram_ctl_pkg::strobes_t PINS;
	vdram_ctl vdram_ctl_inst (.CLK(CLK), .SYS_RST(SYS_RST), .S_AWADDR(S_AWADDR), .S_AWVALID(S_AWVALID),
		.S_AWREADY(S_AWREADY), .S_WDATA(S_WDATA), .S_WSTRB(S_WSTRB), .S_WVALID(S_WVALID), .S_WREADY(S_WREADY),
		.S_BRESP(S_BRESP), .S_BVALID(S_BVALID), .S_BREADY(S_BREADY), .S_ARADDR(S_ARADDR), .S_ARVALID(S_ARVALID),
		.S_ARREADY(S_ARREADY), .S_RDATA(S_RDATA), .S_RRESP(S_RRESP), .S_RVALID(S_RVALID), .S_RREADY(S_RREADY),
		.PINS(PINS), .MASK_DATA_PINS_O(MASK_DATA_PINS_O), .MASK_DATA_PINS_OE_N(MASK_DATA_PINS_OE_N),
		.MASK_DATA_PINS_I(dbus));
	vdram_model vdram_model_inst (.p(PINS), .dq(dbus), .q(q), .drv(drv));
	// A released bus shows the inverse of the model's last output q.
	assign dbus = drv ? q : (MASK_DATA_PINS_OE_N ? ~q : MASK_DATA_PINS_O);
	always #10 CLK = ~CLK;
	task automatic finish_test;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tmo;
		fail_count++;
		finish_test();
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bit aw, w;
		int n;
		S_AWADDR  <= a;
		S_WDATA   <= v;
		S_AWVALID <= 1'b1;
		S_WVALID  <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge CLK);
			if (aw && w && S_BVALID === 1'b1)
				break;
			aw |= (S_AWREADY === 1'b1);
			w  |= (S_WREADY === 1'b1);
			S_AWVALID <= !aw;
			S_WVALID  <= !w;
		end
		if (n == 200)
			tmo();
		chk("write resp", {30'h0, S_BRESP}, {30'h0, vdram_ctl_pkg::RESP_OK});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		int n;
		S_ARADDR  <= a;
		S_ARVALID <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge CLK);
			if (S_RVALID === 1'b1)
				break;
			if (S_ARREADY === 1'b1)
				S_ARVALID <= 1'b0;
		end
		if (n == 200)
			tmo();
		v  = S_RDATA;
		rr = S_RRESP;
	endtask
	task automatic run(input logic [3:0] c, input logic [17:0] ad, input logic [7:0] v, input bit m);
		int n;
		wr(vdram_ctl_pkg::OFF_ADDR, {14'h0, ad});
		wr(vdram_ctl_pkg::OFF_WDATA, {24'h0, v});
		wr(vdram_ctl_pkg::OFF_CMD, {1'b1, 26'h0, m, c});
		for (n = 0; n < 100; n++) begin
			rd(vdram_ctl_pkg::OFF_STATUS, d, r);
			if (d[0] === 1'b0)
				break;
		end
		if (n == 100)
			tmo();
		chk("cycle type", {28'h0, vdram_model_inst.last_op}, {28'h0, c});
	endtask
	task automatic rdm(input logic [17:0] ad, input logic [7:0] e);
		run(vdram_ctl_pkg::OP_READ, ad, 8'h00, 1'b0);
		rd(vdram_ctl_pkg::OFF_RDATA, d, r);
		chk("read data", {24'h0, d[7:0]}, {24'h0, e});
	endtask
	initial begin
		CLK = 0; SYS_RST = 1; S_AWADDR = 0; S_WDATA = 0; S_WSTRB = 4'hF; S_AWVALID = 0; S_WVALID = 0;
		S_BREADY = 1; S_ARADDR = 0; S_ARVALID = 0; S_RREADY = 1; fail_count = 0; check_count = 0;
		ops = '{vdram_ctl_pkg::OP_REFRESH, vdram_ctl_pkg::OP_STOP_SET, vdram_ctl_pkg::OP_ROW_ONLY,
			vdram_ctl_pkg::OP_XFER_RD, vdram_ctl_pkg::OP_XFER_WR, vdram_ctl_pkg::OP_SPLIT_RD, vdram_ctl_pkg::OP_SPLIT_WR};
		repeat (5) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		run(vdram_ctl_pkg::OP_OPT_RESET, 18'h0, 8'h00, 1'b0);
		chk("stop reg", {24'h0, vdram_model_inst.stop}, 32'h000000FF);
		run(vdram_ctl_pkg::OP_WRITE, 18'h00A05, 8'h5A, 1'b0);
		rdm(18'h00A05, 8'h5A);
		run(vdram_ctl_pkg::OP_COLOR, 18'h0, 8'hC3, 1'b0);
		run(vdram_ctl_pkg::OP_MASKREG, 18'h0, 8'hFF, 1'b0);
		run(vdram_ctl_pkg::OP_FLASH, 18'h00C00, 8'h00, 1'b0);
		rdm(18'h00DFF, 8'hC3);
		rdm(18'h00C00, 8'hC3);
		run(vdram_ctl_pkg::OP_MASKREG, 18'h0, 8'h3C, 1'b0);
		run(vdram_ctl_pkg::OP_WRITE, 18'h01234, 8'hF0, 1'b0);
		run(vdram_ctl_pkg::OP_WRITE, 18'h01234, 8'h0F, 1'b1);
		rdm(18'h01234, 8'hCC);
		run(vdram_ctl_pkg::OP_OPT_RESET, 18'h0, 8'h00, 1'b0);
		run(vdram_ctl_pkg::OP_WRITE, 18'h01234, 8'h0F, 1'b1);
		rdm(18'h01234, 8'hCF);
		run(vdram_ctl_pkg::OP_WRITE, 18'h00209, 8'h11, 1'b0);
		run(vdram_ctl_pkg::OP_BLOCK, 18'h0020A, 8'h05, 1'b0);
		rdm(18'h00208, 8'hC3);
		rdm(18'h00209, 8'h11);
		rdm(18'h0020A, 8'hC3);
		for (k = 0; k < 7; k++)
			run(ops[k], 18'h00A05, 8'h00, 1'b0);
		rdm(18'h00A05, 8'h5A);
		rd(8'h20, d, r);
		chk("unmapped resp", {30'h0, r}, {30'h0, vdram_ctl_pkg::RESP_SLVERR});
		chk("unmapped data", d, 32'h0);
		finish_test();
	end
endmodule
